// ---- hw/ebct_pkg.sv ----
// Constants for the external bus cycle timing sequencer
// Behaviour
// - Latched code read lasts 2 to 5 clocks
// - Unlatched code read lasts 1 to 4 clocks
// - Unlatched data read lasts 1 to 4 clocks
// - Latched data read lasts 2 to 5 clocks
// - Read strobe spans cycle minus latch phase
// - Two-byte read keeps read strobe low throughout
// - Write strobe one or two clocks wide
// - Write hold zero or one clock after strobe
// - Write 2 to 5 clocks, setup is remainder
// - Latch end to write strobe gap derived
// - Write data valid early by derived setup
// - Wait sampled relative to the active strobe
// - One-clock read strobe cannot be stretched
// - Writes need the write hold bit set
// - Latch pulse half or one and half clocks
package ebct_pkg;
  localparam logic [7:0] TIMING_LOW_OFS = 8'h00;
  localparam logic [7:0] TIMING_HIGH_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] WDATA_OFS = 8'h0c;
  localparam logic [7:0] CMD_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] RDATA_OFS = 8'h18;
  // bus_timing_low_reg fields
  localparam int UNLATCHED_CODE_CYCLE_LO = 0;
  localparam int LATCHED_CODE_CYCLE_LO = 2;
  localparam int WRITE_STROBE_WIDE = 4;
  localparam int WRITE_HOLD_EXTEND = 5;
  localparam int LATCH_PULSE_WIDE = 6;
  // bus_timing_high_reg fields
  localparam int UNLATCHED_READ_CYCLE_LO = 0;
  localparam int LATCHED_READ_CYCLE_LO = 2;
  localparam int UNLATCHED_WRITE_CYCLE_LO = 4;
  localparam int LATCHED_WRITE_CYCLE_LO = 6;
  // Command register fields
  localparam int CMD_KIND_LO = 0;
  localparam int CMD_LATCHED = 2;
  localparam int CMD_TWO_BYTE = 3;
  localparam int CMD_WR_LOW = 4;
  localparam int CMD_WR_HIGH = 5;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam logic [7:0] TIMING_LOW_RST = 8'h20;
  localparam logic [7:0] TIMING_HIGH_RST = 8'h00;
  // Strobe vector: 0 latch, 1 code read, 2 read, 3 write low, 4 write high
  localparam logic [4:0] STROBE_IDLE_LVL = 5'h1e;
  // Half-clock widths of the latch pulse
  localparam logic [3:0] LATCH_HALVES_NARROW = 4'h1;
  localparam logic [3:0] LATCH_HALVES_WIDE = 4'h3;
  typedef enum logic [1:0] {EBCT_CODE, EBCT_READ, EBCT_WRITE, EBCT_NONE} ebct_kind_e;
  typedef enum {EBCT_IDLE, EBCT_RUN} ebct_state_e;
endpackage

// ---- hw/ebct_bus_timing.sv ----
// External bus cycle sequencer with APB configuration
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module ebct_bus_timing #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic bus_data_oe,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic wait_in,
  output logic ale,
  output logic code_read_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_low_byte_n,
  output logic write_strobe_high_byte_n
);
  logic [7:0] bus_timing_low_reg;
  logic [7:0] bus_timing_high_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic refused;
  ebct_pkg::ebct_state_e state;
  ebct_pkg::ebct_kind_e kind;
  logic latched_ph, two_byte, phase, wr_low, wr_high;
  logic [2:0] k;
  logic [2:0] cap_v, cap_b;
  logic [1:0] wait_s;
  logic [DATA_W-1:0] rd_s1, rd_s2;
  logic wr_acc, start, busy;
  logic [1:0] cmd_kind;
  assign wr_acc = psel & penable & pready & pwrite;
  assign busy = (state == ebct_pkg::EBCT_RUN) | (|cap_v);
  assign cmd_kind = pwdata[ebct_pkg::CMD_KIND_LO +: 2];
  assign start = wr_acc & (paddr == ebct_pkg::CMD_OFS) & !busy &
                 (cmd_kind != 2'h3) &
                 !((cmd_kind == 2'h2) & !bus_timing_low_reg[ebct_pkg::WRITE_HOLD_EXTEND]);
  // Cycle shape, in clocks and half clocks
  logic [2:0] len, str_end_clk;
  logic [3:0] aw, st_s, st_e, str_halves;
  logic hold, wide, stall_ok;
  always_comb begin
    hold = bus_timing_low_reg[ebct_pkg::WRITE_HOLD_EXTEND];
    wide = bus_timing_low_reg[ebct_pkg::WRITE_STROBE_WIDE];
    aw = bus_timing_low_reg[ebct_pkg::LATCH_PULSE_WIDE] ? ebct_pkg::LATCH_HALVES_WIDE
                                                          : ebct_pkg::LATCH_HALVES_NARROW;
    len = 3'h1;
    st_s = 4'h0;
    st_e = 4'h2;
    case (kind)
      ebct_pkg::EBCT_CODE: begin
        len = latched_ph ? 3'h2 + {1'b0, bus_timing_low_reg[ebct_pkg::LATCHED_CODE_CYCLE_LO +: 2]}
                         : 3'h1 + {1'b0, bus_timing_low_reg[ebct_pkg::UNLATCHED_CODE_CYCLE_LO +: 2]};
      end
      ebct_pkg::EBCT_READ: begin
        len = latched_ph ? 3'h2 + {1'b0, bus_timing_high_reg[ebct_pkg::LATCHED_READ_CYCLE_LO +: 2]}
                         : 3'h1 + {1'b0, bus_timing_high_reg[ebct_pkg::UNLATCHED_READ_CYCLE_LO +: 2]};
      end
      ebct_pkg::EBCT_WRITE: begin
        len = latched_ph ? 3'h2 + {1'b0, bus_timing_high_reg[ebct_pkg::LATCHED_WRITE_CYCLE_LO +: 2]}
                         : 3'h2 + {1'b0, bus_timing_high_reg[ebct_pkg::UNLATCHED_WRITE_CYCLE_LO +: 2]};
      end
      default: len = 3'h1;
    endcase
    if (kind == ebct_pkg::EBCT_WRITE) begin
      // strobe placed before width and hold
      st_e = {len - {2'h0, hold}, 1'b0};
      st_s = st_e - {1'b0, wide, ~wide, 1'b0};
    end else begin
      // read strobe after latch plus half clock
      st_s = latched_ph ? aw + 4'h1 : 4'h0;
      st_e = {len, 1'b0};
    end
    str_end_clk = st_e[3:1];
    str_halves = st_e - st_s;
    // one-clock read strobe is never stretched
    stall_ok = (kind != ebct_pkg::EBCT_READ) | (str_halves >= 4'h4);
  end
  logic last, stall;
  // wait held at the strobe's last clock
  assign stall = (k == str_end_clk - 3'h1) & wait_s[1] & stall_ok;
  assign last = (k == len - 3'h1) & !stall;
  // Wanted active state for both halves of clock k
  logic [4:0] act0, act1;
  logic [3:0] h0, h1;
  always_comb begin
    h0 = {k, 1'b0};
    h1 = {k, 1'b1};
    act0 = 5'h00;
    act1 = 5'h00;
    if (state == ebct_pkg::EBCT_RUN) begin
      act0[0] = latched_ph & (h0 < aw);
      act1[0] = latched_ph & (h1 < aw);
      case (kind)
        ebct_pkg::EBCT_CODE: begin
          act0[1] = (h0 >= st_s) & (h0 < st_e);
          act1[1] = (h1 >= st_s) & (h1 < st_e);
        end
        ebct_pkg::EBCT_READ: begin
          act0[2] = (h0 >= st_s) & (h0 < st_e);
          act1[2] = (h1 >= st_s) & (h1 < st_e);
        end
        ebct_pkg::EBCT_WRITE: begin
          act0[3] = wr_low & (h0 >= st_s) & (h0 < st_e);
          act1[3] = wr_low & (h1 >= st_s) & (h1 < st_e);
          act0[4] = wr_high & (h0 >= st_s) & (h0 < st_e);
          act1[4] = wr_high & (h1 >= st_s) & (h1 < st_e);
        end
        default: act0[1] = 1'b0;
      endcase
    end
  end
  // dual-edge outputs, rise and fall flops combined by xor
  logic [4:0] pos_q, neg_q, half1_q, lvl;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= ebct_pkg::STROBE_IDLE_LVL;
      half1_q <= ebct_pkg::STROBE_IDLE_LVL;
    end else begin
      pos_q <= (act0 ^ ebct_pkg::STROBE_IDLE_LVL) ^ neg_q;
      half1_q <= act1 ^ ebct_pkg::STROBE_IDLE_LVL;
    end
  end
  always_ff @(negedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      neg_q <= 5'h00;
    end else begin
      neg_q <= half1_q ^ pos_q;
    end
  end
  // Glitch-free: only one of the two flops toggles per edge
  assign lvl = pos_q ^ neg_q;
  assign ale = lvl[0];
  assign code_read_strobe_n = lvl[1];
  assign read_strobe_n = lvl[2];
  assign write_strobe_low_byte_n = lvl[3];
  assign write_strobe_high_byte_n = lvl[4];
  // Pin inputs pass two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_s <= 2'h0;
      rd_s1 <= '0;
      rd_s2 <= '0;
    end else begin
      wait_s <= {wait_s[0], wait_in};
      rd_s1 <= bus_rdata;
      rd_s2 <= rd_s1;
    end
  end
  // Sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ebct_pkg::EBCT_IDLE;
      kind <= ebct_pkg::EBCT_NONE;
      latched_ph <= 1'b0;
      two_byte <= 1'b0;
      phase <= 1'b0;
      wr_low <= 1'b0;
      wr_high <= 1'b0;
      k <= 3'h0;
    end else if (state == ebct_pkg::EBCT_IDLE) begin
      if (start) begin
        state <= ebct_pkg::EBCT_RUN;
        kind <= ebct_pkg::ebct_kind_e'(cmd_kind);
        latched_ph <= pwdata[ebct_pkg::CMD_LATCHED];
        two_byte <= pwdata[ebct_pkg::CMD_TWO_BYTE] & (cmd_kind == 2'h1);
        phase <= 1'b0;
        wr_low <= pwdata[ebct_pkg::CMD_WR_LOW];
        wr_high <= pwdata[ebct_pkg::CMD_WR_HIGH];
        k <= 3'h0;
      end
    end else if (last) begin
      k <= 3'h0;
      if (two_byte & !phase) begin
        phase <= 1'b1;
        latched_ph <= 1'b0;
      end else begin
        state <= ebct_pkg::EBCT_IDLE;
      end
    end else if (!stall) begin
      k <= k + 3'h1;
    end
  end

  // Address and write data drive
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_addr <= '0;
      bus_wdata <= '0;
      bus_data_oe <= 1'b0;
    end else begin
      bus_addr <= addr_reg | {{(ADDR_W-1){1'b0}}, phase & (state == ebct_pkg::EBCT_RUN)};
      bus_wdata <= wdata_reg;
      // latched write data after latch phase
      bus_data_oe <= (state == ebct_pkg::EBCT_RUN) & (kind == ebct_pkg::EBCT_WRITE) &
                     (!latched_ph | ({k, 1'b0} > aw));
    end
  end

  // Read capture, aligned with synchronised data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_v <= 3'h0;
      cap_b <= 3'h0;
      rdata_reg <= '0;
    end else begin
      cap_v <= {cap_v[1:0], (state == ebct_pkg::EBCT_RUN) & last & (kind != ebct_pkg::EBCT_WRITE)};
      cap_b <= {cap_b[1:0], two_byte & !phase};
      if (cap_v[2]) begin
        if (!two_byte & !cap_b[2]) begin
          rdata_reg <= rd_s2;
        end else if (cap_b[2]) begin
          rdata_reg[7:0] <= rd_s2[7:0];
        end else begin
          rdata_reg[15:8] <= rd_s2[7:0];
        end
      end
    end
  end

  // APB registers
  logic hit;
  assign hit = (paddr == ebct_pkg::TIMING_LOW_OFS) | (paddr == ebct_pkg::TIMING_HIGH_OFS) |
               (paddr == ebct_pkg::ADDR_OFS) | (paddr == ebct_pkg::WDATA_OFS) |
               (paddr == ebct_pkg::CMD_OFS) | (paddr == ebct_pkg::STATUS_OFS) |
               (paddr == ebct_pkg::RDATA_OFS);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_timing_low_reg <= ebct_pkg::TIMING_LOW_RST;
      bus_timing_high_reg <= ebct_pkg::TIMING_HIGH_RST;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (wr_acc & !busy) begin
      // Config frozen while a cycle runs
      case (paddr)
        ebct_pkg::TIMING_LOW_OFS: bus_timing_low_reg <= pwdata[7:0];
        ebct_pkg::TIMING_HIGH_OFS: bus_timing_high_reg <= pwdata[7:0];
        ebct_pkg::ADDR_OFS: addr_reg <= pwdata[ADDR_W-1:0];
        ebct_pkg::WDATA_OFS: wdata_reg <= pwdata[DATA_W-1:0];
        default: addr_reg <= addr_reg;
      endcase
    end
  end
  logic refuse_ev;
  assign refuse_ev = wr_acc & (paddr == ebct_pkg::CMD_OFS) & !start;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refused <= 1'b0;
    end else if (refuse_ev) begin
      refused <= 1'b1;
    end else if (wr_acc & (paddr == ebct_pkg::STATUS_OFS) & pwdata[ebct_pkg::STAT_REFUSED]) begin
      refused <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & !penable;
      pslverr <= psel & !penable & !hit;
      prdata <= 32'h0;
      if (psel & !penable & !pwrite) begin
        case (paddr)
          ebct_pkg::TIMING_LOW_OFS: prdata <= {24'h0, bus_timing_low_reg};
          ebct_pkg::TIMING_HIGH_OFS: prdata <= {24'h0, bus_timing_high_reg};
          ebct_pkg::ADDR_OFS: prdata <= 32'(addr_reg);
          ebct_pkg::WDATA_OFS: prdata <= 32'(wdata_reg);
          ebct_pkg::STATUS_OFS: prdata <= {30'h0, refused, busy};
          ebct_pkg::RDATA_OFS: prdata <= 32'(rdata_reg);
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] run_cnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= 4'h0;
    end else if ((state == ebct_pkg::EBCT_IDLE) | last) begin
      // Each byte of a two-byte read counts from zero
      run_cnt <= 4'h0;
    end else if (!stall & !last) begin
      run_cnt <= run_cnt + 4'h1;
    end
  end
  sequence wr_nohold_s;
    wr_acc && paddr == ebct_pkg::CMD_OFS && cmd_kind == 2'h2 &&
    !bus_timing_low_reg[ebct_pkg::WRITE_HOLD_EXTEND];
  endsequence
  write_hold_refused_a: assert property (wr_nohold_s |=> refused && !$rose(state))
    else $error("write without hold accepted");
  code_len_a: assert property (state == ebct_pkg::EBCT_RUN && last && kind == ebct_pkg::EBCT_CODE
    |-> run_cnt == 4'(len) - 4'h1 && len >= 3'(latched_ph) + 3'h1)
    else $error("code cycle length wrong");
  code_unl_a: assert property (state == ebct_pkg::EBCT_RUN && kind == ebct_pkg::EBCT_CODE &&
    !latched_ph |-> len <= 3'h4)
    else $error("unlatched code cycle too long");
  read_len_a: assert property (state == ebct_pkg::EBCT_RUN && kind == ebct_pkg::EBCT_READ && last
    |-> run_cnt == 4'(len) - 4'h1)
    else $error("read cycle length wrong");
  latch_width_a: assert property ($rose(state == ebct_pkg::EBCT_RUN) && latched_ph
    |-> act0[0] ##1 (ale == bus_timing_low_reg[ebct_pkg::LATCH_PULSE_WIDE]) ##1 !ale)
    else $error("latch pulse width wrong");
  two_byte_a: assert property (state == ebct_pkg::EBCT_RUN && last && two_byte && !phase
    |=> act0[2] ##1 !read_strobe_n)
    else $error("read strobe broken between bytes");
  wr_width_a: assert property (state == ebct_pkg::EBCT_RUN && kind == ebct_pkg::EBCT_WRITE
    |-> str_halves == (wide ? 4'h4 : 4'h2))
    else $error("write strobe width wrong");
  wr_hold_a: assert property (state == ebct_pkg::EBCT_RUN && kind == ebct_pkg::EBCT_WRITE
    |-> {len, 1'b0} - st_e == {2'h0, hold, 1'b0})
    else $error("write hold wrong");
  short_read_a: assert property (state == ebct_pkg::EBCT_RUN && kind == ebct_pkg::EBCT_READ &&
    str_halves < 4'h4 |-> !stall)
    else $error("one clock read stretched");
endmodule

// ---- verif/ebct_far_side.sv ----
// Far-side memory and wait generator for the bus sequencer bench
`timescale 1ns/1ps
module ebct_far_side (
  input wire logic sys_clk,
  input wire logic [19:0] bus_addr,
  input wire logic code_read_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_low_byte_n,
  input wire logic write_strobe_high_byte_n,
  input wire logic [3:0] wait_len,
  output logic [15:0] bus_rdata,
  output logic wait_in
);
  logic [15:0] last_q = 16'h0;
  logic [3:0] a_q = 4'h0;
  logic [3:0] left = 4'h0;
  logic on_q = 1'b0;
  logic rd_on, on;
  assign rd_on = ~(code_read_strobe_n & read_strobe_n);
  assign on = rd_on | ~(write_strobe_low_byte_n & write_strobe_high_byte_n);
  // Released bus toggles so stale data never looks valid
  assign bus_rdata = rd_on ? (bus_addr[15:0] ^ 16'h5a3c) : ~last_q;
  // wait on strobe start or address change during a read strobe
  // Zero wait length must never stretch a cycle
  assign wait_in = (left != 4'h0) || (on && !on_q && wait_len != 4'h0);
  always @(posedge sys_clk) begin
    last_q <= bus_rdata;
    on_q <= on;
    a_q <= bus_addr[3:0];
    if ((on && !on_q) || (rd_on && bus_addr[3:0] != a_q)) begin
      left <= wait_len;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
endmodule

// ---- verif/ebct_bus_timing_test.sv ----
// Self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module ebct_bus_timing_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bus_data_oe, wait_in, ale, sl;
  logic code_read_strobe_n, read_strobe_n, write_strobe_low_byte_n, write_strobe_high_byte_n;
  logic [19:0] bus_addr, ea;
  logic [15:0] bus_wdata, bus_rdata, ed;
  logic [7:0] tlo, thi;
  logic [5:0] act;
  logic [3:0] wait_len = 4'h0;
  logic [1:0] kd, wm;
  logic lt;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  int fi[6], la[6], cn[6];
  int ln, aw, ws, rs, w0, idx, bad;
  longint t0 = 0, tacc = 0;
  always #5 sys_clk = ~sys_clk;
  ebct_bus_timing DUT (.sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_data_oe(bus_data_oe),
    .bus_rdata(bus_rdata), .wait_in(wait_in), .ale(ale), .code_read_strobe_n(code_read_strobe_n),
    .read_strobe_n(read_strobe_n), .write_strobe_low_byte_n(write_strobe_low_byte_n),
    .write_strobe_high_byte_n(write_strobe_high_byte_n));
  ebct_far_side FAR (.sys_clk(sys_clk), .bus_addr(bus_addr),
    .code_read_strobe_n(code_read_strobe_n), .read_strobe_n(read_strobe_n),
    .write_strobe_low_byte_n(write_strobe_low_byte_n),
    .write_strobe_high_byte_n(write_strobe_high_byte_n), .wait_len(wait_len),
    .bus_rdata(bus_rdata), .wait_in(wait_in));
  // Half-clock monitor: strobes move on both edges
  always @(sys_clk) begin
    #1;
    act = {bus_data_oe, ~write_strobe_high_byte_n, ~write_strobe_low_byte_n, ~read_strobe_n,
      ~code_read_strobe_n, ale};
    idx = int'((longint'($time) - 1 - t0) / 5);
    for (int k = 0; k < 6; k++) begin
      if (act[k] === 1'b1 && idx >= 0) begin
        if (fi[k] < 0) fi[k] = idx;
        la[k] = idx;
        cn[k]++;
      end
    end
    if (act[4:3] != 2'b00 && bus_wdata !== ed) bad++;
    if (act[4:1] != 4'h0 && bus_addr[19:1] !== ea[19:1]) bad++;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  function automatic logic [15:0] fx(input logic [19:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic span(input int k, input int s, input int e, input string m);
    chk((s == e) ? (cn[k] == 0) : (fi[k] == s && la[k] == e - 1 && cn[k] == e - s), m);
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tacc = longint'($time);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, "no bus answer");
    @(posedge sys_clk);
  endtask
  task automatic cfg(input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b1, ebct_pkg::TIMING_LOW_OFS, {24'h0, lo});
    apb(1'b1, ebct_pkg::TIMING_HIGH_OFS, {24'h0, hi});
  endtask
  task automatic run(input logic [1:0] k2, input logic l, input logic tw, input logic [1:0] m,
      input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    ea = a;
    ed = d;
    bad = 0;
    apb(1'b1, ebct_pkg::ADDR_OFS, {12'h0, a});
    apb(1'b1, ebct_pkg::WDATA_OFS, {16'h0, d});
    for (int k = 0; k < 6; k++) begin
      fi[k] = -1;
      la[k] = -1;
      cn[k] = 0;
    end
    apb(1'b1, ebct_pkg::CMD_OFS, {26'h0, m, tw, l, k2});
    t0 = tacc + 10;
    do begin
      apb(1'b0, ebct_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 30);
    chk(n < 30, "busy stuck");
  endtask
  initial begin
    void'($urandom(32'hef93));
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, ebct_pkg::TIMING_LOW_OFS, 32'h0);
    chk(rd === 32'h20, "timing low reset value");
    apb(1'b0, 8'h40, 32'h0);
    chk(sl === 1'b1, "unmapped access not flagged");
    cfg(8'h00, 8'h00);
    run(2'd2, 1'b0, 1'b0, 2'd1, 20'h00010, 16'h1234);
    chk(rd[1] === 1'b1 && cn[3] == 0, "write without hold ran");
    apb(1'b1, ebct_pkg::STATUS_OFS, 32'h2);
    apb(1'b0, ebct_pkg::STATUS_OFS, 32'h0);
    chk(rd[1] === 1'b0, "refused flag not cleared");
    run(2'd3, 1'b0, 1'b0, 2'd0, 20'h00020, 16'h0);
    chk(rd[1] === 1'b1 && cn[1] == 0 && cn[2] == 0, "kind three ran");
    apb(1'b1, ebct_pkg::STATUS_OFS, 32'h2);
    cfg(8'h20, 8'h09);
    run(2'd1, 1'b1, 1'b1, 2'd0, 20'h00200, 16'h0);
    span(2, 2, 12, "two-byte strobe broken");
    apb(1'b0, ebct_pkg::RDATA_OFS, 32'h0);
    chk(rd[15:0] === {8'(fx(20'h00201)), 8'(fx(20'h00200))}, "two-byte data");
    wait_len <= 4'h4;
    cfg(8'h23, 8'h00);
    run(2'd1, 1'b0, 1'b0, 2'd0, 20'h00030, 16'h0);
    span(2, 0, 2, "one-clock read stretched");
    cfg(8'h23, 8'h03);
    for (int k = 0; k < 2; k++) begin
      run(2'(k), 1'b0, 1'b0, 2'd0, 20'h00044 + 20'(k * 4), 16'h0);
      chk(cn[k + 1] > 8 && cn[k + 1] <= 24, "wait stretch");
    end
    wait_len <= 4'h0;
    // Random configurations; invalid combinations skipped, not checked
    for (int i = 0; i < 60; i++) begin
      tlo = 8'($urandom) & 8'h7f | 8'h20;
      thi = 8'($urandom);
      kd = 2'($urandom % 3);
      lt = 1'($urandom);
      wm = 2'($urandom % 3 + 1);
      aw = tlo[6] ? 3 : 1;
      ws = tlo[4] ? 2 : 1;
      if (kd == 0) ln = lt ? tlo[3:2] + 2 : tlo[1:0] + 1;
      else if (kd == 1) ln = lt ? thi[3:2] + 2 : thi[1:0] + 1;
      else ln = lt ? thi[7:6] + 2 : thi[5:4] + 2;
      rs = lt ? aw + 1 : 0;
      w0 = 2 * (ln - ws - 1);
      if ((kd == 2 && w0 < rs) || (kd != 2 && 2 * ln <= rs)) continue;
      cfg(tlo, thi);
      run(kd, lt, 1'b0, wm, 20'($urandom), 16'($urandom));
      span(0, 0, lt ? aw : 0, "latch pulse");
      span(1, rs, kd == 0 ? 2 * ln : rs, "code strobe");
      span(2, rs, kd == 1 ? 2 * ln : rs, "read strobe");
      span(3, w0, kd == 2 && wm[0] ? 2 * ln - 2 : w0, "low write strobe");
      span(4, w0, kd == 2 && wm[1] ? 2 * ln - 2 : w0, "high write strobe");
      chk(kd != 2 || (fi[5] <= rs && la[5] >= 2 * ln - 1 && bad == 0), "write pins");
      if (kd == 1) begin
        apb(1'b0, ebct_pkg::RDATA_OFS, 32'h0);
        chk(rd[15:0] === fx(ea), "read data");
      end
    end
    print_verdict();
  end
endmodule
